/* hw/tmr_regs.svh */
// register map, field positions, reset values and timing counts
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// byte offsets of the register words
`define TMR_OFS_CNT0    8'h00
`define TMR_OFS_CTL0    8'h04
`define TMR_OFS_CNT1    8'h08
`define TMR_OFS_CTL1    8'h0c
`define TMR_OFS_STAT    8'h10
`define TMR_OFS_MASK    8'h14
`define TMR_OFS_VEC     8'h18

// control register fields
`define TMR_CTL_PRE_LSB 0
`define TMR_CTL_PRE_MSB 2
`define TMR_CTL_RUN     4

// reset values
`define TMR_RST_CTL     8'h00
`define TMR_RST_CNT     8'h00
`define TMR_RST_IRQ     2'h0

// interrupt vector addresses per timer
`define TMR_VEC0        8'h08
`define TMR_VEC1        8'h0c
`define TMR_VEC_NONE    8'h00

// fixed system clock divider ahead of the prescaler
`define TMR_SYS_DIV     4

`endif

/* hw/tmr_pkg.sv */
// types shared by the dual timer and its channel module
// assumes nothing beyond a systemverilog elaborator
package tmr_pkg;
	typedef logic [7:0] reg8_t;          // one 8-bit timer register
	typedef enum logic [1:0] {
		RESP_OKAY   = 2'b00,
		RESP_SLVERR = 2'b10
	} axi_resp_t;                        // axi response codes used
endpackage

/* hw/timer_chan_if.sv */
// carrier between the register block and one timer channel
// assumes one clock domain; no clocking block needed
`timescale 1ns/1ps
interface timer_chan_if;
	import tmr_pkg::*;
	reg8_t ctl;       // control register contents
	logic  wr_count;  // one-cycle write strobe to the count register
	reg8_t wr_data;   // data with that strobe
	logic  rd_hold;   // count register being read this cycle
	reg8_t count;     // live counter value
	logic  ovf;       // one-cycle overflow pulse
	modport ctrl (output ctl, wr_count, wr_data, rd_hold,
		input count, ovf);
	modport chan (input ctl, wr_count, wr_data, rd_hold,
		output count, ovf);
endinterface

/* hw/timer_channel.sv */
// one 8-bit count-up timer with div-by-4 and 3-bit prescaler
// assumes synchronous strobes from the register block on i_clk
`timescale 1ns/1ps
`include "tmr_regs.svh"
module timer_channel #(
	parameter int DIV = `TMR_SYS_DIV     // fixed input divider
) (
	input wire logic   i_clk,
	input wire logic   i_arst_n,
	timer_chan_if.chan bus
);
	import tmr_pkg::*;
	localparam int DW = $clog2(DIV);
	localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

	logic [DW-1:0] div_cnt;   // system clock divider
	logic [7:0]    pre_cnt;   // prescaler stages
	reg8_t         preload;   // reload value
	reg8_t         count;     // live count
	logic          run;       // run control from control bit 4
	logic [2:0]    pre_sel;   // prescaler select code
	logic [7:0]    pre_mask;  // low bits that must all be one
	logic          div_tick;  // one pulse per DIV system clocks
	logic          pre_tick;  // prescaled count pulse
	logic          cnt_tick;  // pulse that really counts

	assign run      = bus.ctl[`TMR_CTL_RUN];
	assign pre_sel  = bus.ctl[`TMR_CTL_PRE_MSB:`TMR_CTL_PRE_LSB];
	// code n gives ratio 2^(n+1)
	assign pre_mask = 8'((9'h002 << pre_sel) - 9'h001);
	assign div_tick = (div_cnt == DIV_LAST);
	assign pre_tick = div_tick && run &&
		((pre_cnt & pre_mask) == pre_mask);
	// a read blocks the pulse; it is lost, not deferred
	assign cnt_tick = pre_tick && !bus.rd_hold;
	assign bus.ovf  = cnt_tick && (count == 8'hff);
	assign bus.count = count;

	// free-running divide by four of the system clock
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_tick ? '0 : div_cnt + 1'b1;
		end
	end

	// prescaler runs only while the timer is on
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pre_cnt <= 8'h00;
		end else if (!run) begin
			pre_cnt <= 8'h00;
		end else if (div_tick) begin
			pre_cnt <= pre_cnt + 8'h01;
		end
	end

	// preload register: every write lands here
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			preload <= `TMR_RST_CNT;
		end else if (bus.wr_count) begin
			preload <= bus.wr_data;
		end
	end

	// counter: write when off, count, reload on overflow
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count <= `TMR_RST_CNT;
		end else if (bus.wr_count && !run) begin
			count <= bus.wr_data;
		end else if (bus.ovf) begin
			count <= preload;
		end else if (cnt_tick) begin
			count <= count + 8'h01;
		end
	end

	chk_count_step: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		cnt_tick && count != 8'hff && !(bus.wr_count && !run)
		|=> count == $past(count) + 8'h01)
		else $error("count did not step by one");
	chk_reload_value: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		bus.ovf && run |=> count == $past(preload))
		else $error("overflow did not reload preload");
	chk_tick_spacing: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		cnt_tick |=> !cnt_tick [*7])
		else $error("count pulses closer than eight clocks");
	chk_run_write: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		bus.wr_count && run && !cnt_tick
		|=> count == $past(count) && preload == $past(bus.wr_data))
		else $error("running write touched the counter");
	chk_off_hold: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		!run && !bus.wr_count |=> $stable(count))
		else $error("stopped timer changed its count");
	chk_read_block: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		bus.rd_hold && !bus.wr_count |=> $stable(count))
		else $error("count moved during a read");
endmodule // timer_channel

/* hw/dual_timer_top.sv */
// two 8-bit timers behind an axi4-lite slave with interrupt logic
// assumes the bus master and the interrupt acknowledge share
// I_SYS_CLK; one write and one read at most in flight
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "tmr_regs.svh"

// Behaviour
// - timer input clock is system clock over four
// - prescaler ratio picked by control bits 0-2
// - counter steps by one per prescaled pulse
// - passing FFH overflows and raises a request
// - overflow reloads preload and keeps counting
// - zero preload gives full 256-count range
// - write while off loads preload and counter
// - write while running loads preload only
// - count register read returns live counter
// - reading the count blocks its count pulse
// - control bit 4 runs or holds the timer
// - enable bit gates each overflow request
// - two independent timers, each fully separate
// - timer 0 request vectors to address 08h
module dual_timer_top
	import tmr_pkg::*;
(
	input  wire logic       I_SYS_CLK,
	input  wire logic       I_ARST_N,
	// axi4-lite write address
	input  wire logic       I_AWVALID,
	output logic            O_AWREADY,
	input  wire logic [7:0] I_AWADDR,
	// axi4-lite write data
	input  wire logic       I_WVALID,
	output logic            O_WREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0] I_WSTRB,
	// axi4-lite write response
	output logic            O_BVALID,
	input  wire logic       I_BREADY,
	output tmr_pkg::axi_resp_t O_BRESP,
	// axi4-lite read address
	input  wire logic       I_ARVALID,
	output logic            O_ARREADY,
	input  wire logic [7:0] I_ARADDR,
	// axi4-lite read data
	output logic            O_RVALID,
	input  wire logic       I_RREADY,
	output logic [31:0]     O_RDATA,
	output tmr_pkg::axi_resp_t O_RRESP,
	// interrupt to the core
	output logic            O_IRQ,
	output tmr_pkg::reg8_t  O_IRQ_VECTOR,
	input  wire logic       I_IRQ_ACK
);
	import tmr_pkg::*;

	localparam int NT = 2; // timer count

	// write channel state
	logic       aw_have;   // address held
	logic       w_have;    // data held
	logic [7:0] waddr;     // held write address, word aligned
	logic [7:0] wdata;     // held low byte of write data
	logic       wlane;     // byte lane 0 strobe held
	logic       do_wr;     // both halves present, response free
	logic       wr_lane;   // write that really stores
	logic       wr_ok;     // write address is mapped

	// read channel state
	logic       ar_fire;   // read address taken this cycle
	logic [7:0] raddr;     // aligned read address
	logic [31:0] rd_mux;   // read data before the flop
	logic       rd_ok;     // read address is mapped

	// timer and interrupt state
	reg8_t      ctl [NT];  // control registers
	logic [1:0] status;    // sticky overflow flags
	logic [1:0] mask;      // interrupt enables
	logic [1:0] ovf;       // overflow pulses from channels
	logic [1:0] pend;      // enabled and pending
	logic [1:0] w1c;       // software clear of flags
	logic [1:0] ack_clr;   // clear by interrupt acceptance
	logic [1:0] next_status;
	reg8_t      cnt_val [NT];

	timer_chan_if chan_bus [NT] ();

	// one identical channel per timer
	for (genvar i = 0; i < NT; i++) begin : g_tmr
		localparam logic [7:0] OFS_CNT =
			(i == 0) ? `TMR_OFS_CNT0 : `TMR_OFS_CNT1;
		localparam logic [7:0] OFS_CTL =
			(i == 0) ? `TMR_OFS_CTL0 : `TMR_OFS_CTL1;

		// control register, software owned
		always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
			if (!I_ARST_N) begin
				ctl[i] <= `TMR_RST_CTL;
			end else if (wr_lane && waddr == OFS_CTL) begin
				ctl[i] <= wdata;
			end
		end

		assign chan_bus[i].ctl      = ctl[i];
		assign chan_bus[i].wr_count = wr_lane && waddr == OFS_CNT;
		assign chan_bus[i].wr_data  = wdata;
		// the access cycle drops this timer's count pulse
		assign chan_bus[i].rd_hold  = ar_fire &&
			raddr == OFS_CNT;
		assign cnt_val[i] = chan_bus[i].count;
		assign ovf[i]     = chan_bus[i].ovf;

		timer_channel #(
			.DIV (`TMR_SYS_DIV)
		) u_chan (
			.i_clk    (I_SYS_CLK),
			.i_arst_n (I_ARST_N),
			.bus      (chan_bus[i])
		);
	end

	// write address and data accepted independently
	assign O_AWREADY = !aw_have && !O_BVALID;
	assign O_WREADY  = !w_have && !O_BVALID;
	assign do_wr     = aw_have && w_have && !O_BVALID;
	assign wr_lane   = do_wr && wlane;

	// hold the write address until the write is done
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			aw_have <= 1'b0;
			waddr   <= 8'h00;
		end else if (I_AWVALID && O_AWREADY) begin
			aw_have <= 1'b1;
			waddr   <= {I_AWADDR[7:2], 2'b00};
		end else if (do_wr) begin
			aw_have <= 1'b0;
		end
	end

	// hold write data; only byte lane 0 carries register bits
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			w_have <= 1'b0;
			wdata  <= 8'h00;
			wlane  <= 1'b0;
		end else if (I_WVALID && O_WREADY) begin
			w_have <= 1'b1;
			wdata  <= I_WDATA[7:0];
			wlane  <= I_WSTRB[0];
		end else if (do_wr) begin
			w_have <= 1'b0;
		end
	end

	// vector register is read-only: writes to it are refused
	always_comb begin
		unique case (waddr)
			`TMR_OFS_CNT0, `TMR_OFS_CTL0,
			`TMR_OFS_CNT1, `TMR_OFS_CTL1,
			`TMR_OFS_STAT, `TMR_OFS_MASK: wr_ok = 1'b1;
			default:                      wr_ok = 1'b0;
		endcase
	end

	// write response one cycle after both halves arrive
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_BVALID <= 1'b0;
			O_BRESP  <= RESP_OKAY;
		end else if (do_wr) begin
			O_BVALID <= 1'b1;
			O_BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (I_BREADY) begin
			O_BVALID <= 1'b0;
		end
	end

	// read: one outstanding, answered the cycle after it is taken
	assign O_ARREADY = !O_RVALID;
	assign ar_fire   = I_ARVALID && O_ARREADY;
	assign raddr     = {I_ARADDR[7:2], 2'b00};

	// read mux; count reads show the live counter
	always_comb begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (raddr)
			`TMR_OFS_CNT0: rd_mux[7:0] = cnt_val[0];
			`TMR_OFS_CTL0: rd_mux[7:0] = ctl[0];
			`TMR_OFS_CNT1: rd_mux[7:0] = cnt_val[1];
			`TMR_OFS_CTL1: rd_mux[7:0] = ctl[1];
			`TMR_OFS_STAT: rd_mux[1:0] = status;
			`TMR_OFS_MASK: rd_mux[1:0] = mask;
			`TMR_OFS_VEC:  rd_mux[7:0] = O_IRQ_VECTOR;
			default:       rd_ok       = 1'b0;
		endcase
	end

	// read data flop, held until the master takes it
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_RVALID <= 1'b0;
			O_RDATA  <= 32'h0000_0000;
			O_RRESP  <= RESP_OKAY;
		end else if (ar_fire) begin
			O_RVALID <= 1'b1;
			O_RDATA  <= rd_mux;
			O_RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (I_RREADY) begin
			O_RVALID <= 1'b0;
		end
	end

	// interrupt enable register
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			mask <= `TMR_RST_IRQ;
		end else if (wr_lane && waddr == `TMR_OFS_STAT + 8'h04) begin
			mask <= wdata[1:0];
		end
	end

	assign pend = status & mask;
	// acceptance clears the served flag: timer 0 has priority
	assign ack_clr = I_IRQ_ACK ? (pend & (~pend + 2'b01)) : 2'b00;
	assign w1c = (wr_lane && waddr == `TMR_OFS_STAT) ?
		wdata[1:0] : 2'b00;
	// a new overflow beats a clear in the same cycle
	assign next_status = (status & ~(w1c | ack_clr)) | ovf;

	// sticky flags until software or acceptance clears them
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			status <= `TMR_RST_IRQ;
		end else begin
			status <= next_status;
		end
	end

	// vector of the highest-priority enabled request
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_IRQ_VECTOR <= `TMR_VEC_NONE;
		end else if (pend[0]) begin
			O_IRQ_VECTOR <= `TMR_VEC0;
		end else if (pend[1]) begin
			O_IRQ_VECTOR <= `TMR_VEC1;
		end else begin
			O_IRQ_VECTOR <= `TMR_VEC_NONE;
		end
	end

	// level request to the core
	assign O_IRQ = |pend;

	chk_flag_set: assert property (@(posedge I_SYS_CLK)
		disable iff (!I_ARST_N)
		ovf[0] |=> status[0])
		else $error("overflow did not set flag 0");
	chk_flag_sticky: assert property (@(posedge I_SYS_CLK)
		disable iff (!I_ARST_N)
		status[1] && !w1c[1] && !ack_clr[1] |=> status[1])
		else $error("flag 1 dropped without a clear");
	chk_irq_gated: assert property (@(posedge I_SYS_CLK)
		disable iff (!I_ARST_N)
		mask == 2'b00 |-> !O_IRQ)
		else $error("request passed a zero enable");
	chk_vector_zero: assert property (@(posedge I_SYS_CLK)
		disable iff (!I_ARST_N)
		status[0] && mask[0] |=> O_IRQ_VECTOR == `TMR_VEC0)
		else $error("timer 0 vector wrong");
	chk_read_live: assert property (@(posedge I_SYS_CLK)
		disable iff (!I_ARST_N)
		ar_fire && raddr == `TMR_OFS_CNT1
		|=> O_RVALID && O_RDATA[7:0] == $past(cnt_val[1]))
		else $error("count read not the live counter");
	chk_ack_clear: assert property (@(posedge I_SYS_CLK)
		disable iff (!I_ARST_N)
		I_IRQ_ACK && pend[0] && !ovf[0] |=> !status[0])
		else $error("acceptance left flag 0 set");

	cov_overflow0: cover property (@(posedge I_SYS_CLK)
		disable iff (!I_ARST_N) ovf[0] && mask[0]);
	cov_ack: cover property (@(posedge I_SYS_CLK)
		disable iff (!I_ARST_N) I_IRQ_ACK && pend[1]);
	cov_set_wins: cover property (@(posedge I_SYS_CLK)
		disable iff (!I_ARST_N) (w1c[0] && ovf[0]));
endmodule // dual_timer_top

/* verif/test_dual_timer_top.sv */
// self-checking bench for the dual 8-bit timer behind axi4-lite
// assumes the design files under hw/ and a 25 mhz system clock
`timescale 1ns/1ps
`include "tmr_regs.svh"
module test_dual_timer_top;
	import tmr_pkg::*;
	localparam int          DIV     = `TMR_SYS_DIV;
	localparam logic [31:0] CTL_OFF = 32'h40; // bits 7:6 = 01
	localparam logic [31:0] CTL_RUN = 32'h50; // same plus run bit
	logic        clk, arst_n, irq_ack;  // clock, reset, core accept
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [7:0]  awaddr, araddr;         // byte addresses
	logic [31:0] wdata, rdata, d0, d;    // bus data and saved reads
	logic [3:0]  wstrb;
	axi_resp_t   bresp, rresp, r;
	reg8_t       irq_vector;
	int          n_errors, samples_checked, cyc, t1, t2, t3, i, n;
	logic [7:0]  pre;                    // preload under test

	dual_timer_top u_dual_timer_top (
		.I_SYS_CLK(clk), .I_ARST_N(arst_n),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
		.I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
		.I_WSTRB(wstrb), .O_BVALID(bvalid), .I_BREADY(bready),
		.O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready),
		.O_RDATA(rdata), .O_RRESP(rresp), .O_IRQ(irq),
		.O_IRQ_VECTOR(irq_vector), .I_IRQ_ACK(irq_ack)
	);

	// free clock and a cycle count for measuring overflow periods
	initial clk = 1'b0;
	always #20 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	// one comparison, counted; mismatches reported at once
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s seen %h expected %h",
				$time, what, seen, exp);
		end
	endtask

	// ready is combinational, so it is looked at on the falling edge,
	// which shows what the next rising edge will take
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
		output axi_resp_t rs);
		logic a_done, w_done, a_hit, w_hit;
		int   k;
		a_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v;
		wstrb <= 4'hf; bready <= 1'b1;
		for (k = 0; k < 100 && !(a_done && w_done); k++) begin
			@(negedge clk);
			a_hit = !a_done && awready;
			w_hit = !w_done && wready;
			@(posedge clk);
			if (a_hit) begin
				awvalid <= 1'b0; a_done = 1'b1;
			end
			if (w_hit) begin
				wvalid <= 1'b0; w_done = 1'b1;
			end
		end
		for (k = 0; k < 100; k++) begin
			@(negedge clk);
			if (bvalid === 1'b1) break;
		end
		check(32'(k < 100), 32'h1, "write response wait");
		rs = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
		output axi_resp_t rs);
		logic hit;
		int   k;
		@(posedge clk);
		arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(negedge clk);
			hit = arready;
			@(posedge clk);
			if (hit) begin
				arvalid <= 1'b0; break;
			end
		end
		for (k = 0; k < 100; k++) begin
			@(negedge clk);
			if (rvalid === 1'b1) break;
		end
		check(32'(k < 100), 32'h1, "read data wait");
		v = rdata; rs = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		axi_resp_t rs;
		axi_write(a, v, rs);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		axi_resp_t   rs;
		axi_read(a, v, rs);
		check(v, exp, "register read");
	endtask

	// returns the cycle at which the interrupt line is first seen high
	task automatic wait_irq(output int t);
		int k;
		for (k = 0; k < 5000; k++) begin
			@(negedge clk);
			if (irq === 1'b1) break;
		end
		check(32'(k < 5000), 32'h1, "interrupt wait");
		t = cyc;
	endtask

	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// hang guard, well past the roughly 13k cycles the tests need
	initial begin
		repeat (80000) @(posedge clk);
		n_errors++;
		print_verdict;
	end

	// main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, irq_ack} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		arst_n = 1'b0; cyc = 0; n_errors = 0; samples_checked = 0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		// reset values, read-only vector, unmapped place
		for (i = 0; i < 6; i++) rd_chk(8'(i * 4), 32'h0);
		rd_chk(`TMR_OFS_VEC, 32'h0);
		axi_read(8'h1c, d, r);
		check(d, 32'h0, "unmapped read data");
		check(32'(r), 32'(RESP_SLVERR), "unmapped read resp");
		axi_write(`TMR_OFS_VEC, 32'hff, r);
		check(32'(r), 32'(RESP_SLVERR), "vector write resp");
		axi_write(`TMR_OFS_CTL0, 32'h47, r);
		check(32'(r), 32'(RESP_OKAY), "mapped write resp");
		rd_chk(`TMR_OFS_CTL0, 32'h47);
		wr(`TMR_OFS_CTL1, 32'h43);
		rd_chk(`TMR_OFS_CTL1, 32'h43);
		wr(`TMR_OFS_CTL0, CTL_OFF);
		wr(`TMR_OFS_CTL1, CTL_OFF);
		wr(`TMR_OFS_CNT0, 32'ha5);
		rd_chk(`TMR_OFS_CNT0, 32'ha5);
		rd_chk(`TMR_OFS_CNT1, 32'h0);
		$display("test done: register map");
		// every prescale code, plus a zero preload for full range
		wr(`TMR_OFS_MASK, 32'h1);
		for (i = 0; i < 9; i++) begin
			n = (i < 8) ? i : 0;
			pre = (i < 8) ? 8'hfe : 8'h00;
			wr(`TMR_OFS_CTL0, CTL_OFF);
			wr(`TMR_OFS_CNT0, 32'(pre)); // value before run
			wr(`TMR_OFS_STAT, 32'h3);
			wr(`TMR_OFS_CTL0, CTL_RUN | 32'(n));
			wait_irq(t1);
			repeat (2) @(negedge clk);
			check(32'(irq_vector), 32'(`TMR_VEC0), "vector");
			wr(`TMR_OFS_STAT, 32'h1);
			wait_irq(t2);
			check(32'(t2 - t1), 32'((256 - int'(pre)) * DIV * (2 ** (n + 1))),
				"overflow period");
		end
		$display("test done: prescaler sweep");
		// new preload while running waits for the next overflow
		wr(`TMR_OFS_CTL0, CTL_OFF);
		wr(`TMR_OFS_CNT0, 32'hfe);
		wr(`TMR_OFS_STAT, 32'h1);
		wr(`TMR_OFS_CTL0, CTL_RUN);
		wait_irq(t1);
		wr(`TMR_OFS_CNT0, 32'hfc);
		wr(`TMR_OFS_STAT, 32'h1);
		wait_irq(t2);
		wr(`TMR_OFS_STAT, 32'h1);
		wait_irq(t3);
		check(32'(t2 - t1), 32'(2 * DIV * 2), "old preload");
		check(32'(t3 - t2), 32'(4 * DIV * 2), "new preload");
		// stopping holds the count
		wr(`TMR_OFS_CTL0, CTL_OFF);
		axi_read(`TMR_OFS_CNT0, d0, r);
		repeat (100) @(posedge clk);
		rd_chk(`TMR_OFS_CNT0, d0);
		$display("test done: preload and run control");
		// masked request stays pending, unmasking raises the line
		wr(`TMR_OFS_MASK, 32'h0);
		wr(`TMR_OFS_STAT, 32'h3);
		wr(`TMR_OFS_CNT0, 32'hfe);
		wr(`TMR_OFS_CTL0, CTL_RUN);
		repeat (40) @(posedge clk);
		wr(`TMR_OFS_CTL0, CTL_OFF);
		@(negedge clk);
		check(32'(irq), 32'h0, "masked line");
		rd_chk(`TMR_OFS_STAT, 32'h1);
		wr(`TMR_OFS_MASK, 32'h1);
		@(negedge clk);
		check(32'(irq), 32'h1, "unmasked line");
		@(posedge clk);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		rd_chk(`TMR_OFS_STAT, 32'h0);
		@(negedge clk);
		check(32'(irq), 32'h0, "line after accept");
		$display("test done: interrupt mask and accept");
		// second timer on its own, first one left alone
		axi_read(`TMR_OFS_CNT0, d0, r);
		wr(`TMR_OFS_MASK, 32'h2);
		wr(`TMR_OFS_CNT1, 32'hfe);
		wr(`TMR_OFS_CTL1, CTL_RUN);
		wait_irq(t1);
		repeat (2) @(negedge clk);
		check(32'(irq_vector), 32'(`TMR_VEC1), "vector 1");
		rd_chk(`TMR_OFS_STAT, 32'h2);
		rd_chk(`TMR_OFS_CNT0, d0);
		wr(`TMR_OFS_CTL1, CTL_OFF);
		$display("test done: second timer");
		print_verdict;
	end
endmodule // test_dual_timer_top
